/* design/icd_top.sv */
// Impedance control decoder: serial slave, registers, command decode
// What this block does
// - Control word lives at 80h high, 81h low
// - Top five control bits form command field
// - Control word resets to A000h, powered down
// - Zero command does nothing, exits fuse mode
// - Decode init, sweep, increment, repeat, temp, power
// - Control bit 10 selects external calibration
// - Real at 94h-95h, imaginary 96h-97h, read-only
// - With PEC, commit byte only after check
// - Control bit 7 selects gain five or one
// - Start frequency 24 bits from 82h, high first
// - Increment count is nine bits at 88h-89h
`timescale 1ns/1ns
module icd_top
  import icd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        pec_en,
  input  wire logic        fuse_enter,
  input  wire logic        res_valid,
  input  wire logic [15:0] res_real,
  input  wire logic [15:0] res_imag,
  output logic [15:0]      ctrl_word,
  output logic [23:0]      start_freq,
  output logic [8:0]       num_incr,
  output icd_cmd_t         cmd_strobe,
  output icd_op_t          op_state,
  output logic             fuse_mode,
  output logic             ext_cal,
  output logic             gain_x1
);

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisation and bus conditions
  logic [2:0] pins_s;        // {pec_en, sda, scl} after two flops
  logic       scl_s;         // Synchronised clock line
  logic       sda_s;         // Synchronised data line
  logic       pec_s;         // Synchronised PEC enable strap
  logic       scl_d_r;       // Clock line one cycle ago
  logic       sda_d_r;       // Data line one cycle ago

  icd_sync #(.W(3)) u_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in ({pec_en, sda_in, scl_in}),
    .sync_out (pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign pec_s = pins_s[2];

  wire scl_rise  = scl_s & ~scl_d_r;
  wire scl_fall  = ~scl_s & scl_d_r;
  wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  //////////////////////////////////////////////////////////////////////
  // Byte engine state
  icd_sb_t    sb_r;          // Engine state
  logic [3:0] bit_r;         // Bits moved in current byte
  logic [1:0] byte_r;        // 0 address, 1 pointer, 2 data (saturates)
  logic       rw_r;          // Transaction direction, 1 is read
  logic [7:0] sh_r;          // Receive shift register
  logic [7:0] tx_r;          // Transmit shift register
  logic [7:0] ptr_r;         // Register pointer, auto-increments
  logic [7:0] crc_r;         // Running PEC over the transaction
  logic       pend_r;        // Data byte staged, awaiting its PEC
  logic [7:0] pend_addr_r;   // Staged address
  logic [7:0] pend_data_r;   // Staged data
  logic       sda_oe_r;      // Pulls data line low when set

  wire [7:0] crc_nxt = {crc_r[6:0], 1'b0}
                     ^ ((crc_r[7] ^ sda_s) ? CRC_POLY : 8'h00);
  wire byte_done = (sb_r == SB_RX) && scl_fall
                && (bit_r == BITS_PER_BYTE);
  wire addr_hit  = (sh_r[7:1] == DEV_ADDR);
  wire data_byte = byte_done && (byte_r == 2'h2) && !rw_r;
  wire pec_byte  = data_byte && pec_s && pend_r;
  wire pec_ok    = (crc_r == 8'h00);  // Residue is zero on a good PEC
  wire ack_w     = (byte_r == 2'h0) ? addr_hit
                 : (pec_byte ? pec_ok : 1'b1);
  wire [1:0] byte_inc = (byte_r == 2'h2) ? byte_r : byte_r + 2'h1;

  // Commit path: direct without PEC, on good PEC otherwise
  icd_wr_t wr;
  assign wr.en   = data_byte && (pec_s ? (pend_r && pec_ok) : 1'b1);
  assign wr.addr = pec_s ? pend_addr_r : ptr_r;
  assign wr.data = pec_s ? pend_data_r : sh_r;

  //////////////////////////////////////////////////////////////////////
  // Register read selection; unmapped and write-only space reads zero
  logic [15:0] ctrl_r;
  logic [23:0] sfreq_r;
  logic [8:0]  ninc_r;
  logic [15:0] real_r;
  logic [15:0] imag_r;
  logic [7:0]  chk_r;
  wire [7:0] rd_byte =
      (ptr_r == ADDR_CTRL_HI)  ? ctrl_r[15:8]  :
      (ptr_r == ADDR_CTRL_LO)  ? ctrl_r[7:0]   :
      (ptr_r == ADDR_SFREQ_HI) ? sfreq_r[23:16] :
      (ptr_r == ADDR_SFREQ_MD) ? sfreq_r[15:8] :
      (ptr_r == ADDR_SFREQ_LO) ? sfreq_r[7:0]  :
      (ptr_r == ADDR_NINC_HI)  ? {7'h00, ninc_r[NINC_MSB]} :
      (ptr_r == ADDR_NINC_LO)  ? ninc_r[7:0]   :
      (ptr_r == ADDR_REAL_HI)  ? real_r[15:8]  :
      (ptr_r == ADDR_REAL_LO)  ? real_r[7:0]   :
      (ptr_r == ADDR_IMAG_HI)  ? imag_r[15:8]  :
      (ptr_r == ADDR_IMAG_LO)  ? imag_r[7:0]   :
      (ptr_r == ADDR_CHKSUM)   ? chk_r         : 8'h00;

  //////////////////////////////////////////////////////////////////////
  // Serial byte engine; start and stop win over any bit activity
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      sb_r <= SB_IDLE;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      rw_r <= 1'b0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      crc_r <= 8'h00;
      pend_r <= 1'b0;
      pend_addr_r <= 8'h00;
      pend_data_r <= 8'h00;
      sda_oe_r <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      if (start_det) begin
        // Repeated start keeps the pointer for a following read
        sb_r <= SB_RX;
        bit_r <= 4'h0;
        byte_r <= 2'h0;
        crc_r <= 8'h00;
        pend_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else if (stop_det) begin
        // A staged byte without its PEC is dropped here
        sb_r <= SB_IDLE;
        pend_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else begin
        case (sb_r)
          SB_RX: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_s};
              crc_r <= crc_nxt;
              bit_r <= bit_r + 4'h1;
            end else if (byte_done) begin
              sda_oe_r <= ack_w;
              sb_r <= ack_w ? SB_ACK : SB_IDLE;
              if (byte_r == 2'h0) begin
                rw_r <= sh_r[0];
              end
              if (byte_r == 2'h1) begin
                ptr_r <= sh_r;
              end
              if (data_byte) begin
                if (pec_s && !pend_r) begin
                  // Stage the byte until its PEC arrives
                  pend_r <= 1'b1;
                  pend_addr_r <= ptr_r;
                  pend_data_r <= sh_r;
                  ptr_r <= ptr_r + 8'h01;
                end else if (pec_s) begin
                  pend_r <= 1'b0;
                end else begin
                  ptr_r <= ptr_r + 8'h01;
                end
              end
            end
          end
          SB_ACK: begin
            if (scl_fall) begin
              byte_r <= byte_inc;
              bit_r <= 4'h0;
              if (rw_r) begin
                sb_r <= SB_TX;
                tx_r <= rd_byte;
                sda_oe_r <= ~rd_byte[7];
                ptr_r <= ptr_r + 8'h01;
              end else begin
                sb_r <= SB_RX;
                sda_oe_r <= 1'b0;
              end
            end
          end
          SB_TX: begin
            if (scl_fall) begin
              if (bit_r == 4'h7) begin
                sb_r <= SB_RACK;
                sda_oe_r <= 1'b0;
              end else begin
                tx_r <= {tx_r[6:0], 1'b0};
                sda_oe_r <= ~tx_r[6];
                bit_r <= bit_r + 4'h1;
              end
            end
          end
          SB_RACK: begin
            // Master NACK ends the read; ACK fetches the next byte
            if (scl_rise && sda_s) begin
              sb_r <= SB_IDLE;
            end else if (scl_fall) begin
              sb_r <= SB_TX;
              bit_r <= 4'h0;
              tx_r <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
              ptr_r <= ptr_r + 8'h01;
            end
          end
          default: sb_r <= SB_IDLE;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Command decode on a committed write of the high control byte
  wire        ctrl_hi_wr = wr.en && (wr.addr == ADDR_CTRL_HI);
  wire [15:0] ctrl_new   = {wr.data, ctrl_r[7:0]};
  wire [4:0]  cmd_w      = ctrl_new[CMD_MSB:CMD_LSB];
  wire is_run = (cmd_w == CMD_INIT) || (cmd_w == CMD_SWEEP)
             || (cmd_w == CMD_INCR) || (cmd_w == CMD_REPEAT)
             || (cmd_w == CMD_TEMP);
  wire is_nop = ctrl_hi_wr && (cmd_w == CMD_NOP);
  icd_op_t op_nxt;
  // Reserved and no-op codes fall through to the current state
  assign op_nxt = !ctrl_hi_wr          ? op_state  :
                  is_run               ? OP_ACTIVE :
                  (cmd_w == CMD_PDOWN) ? OP_PDOWN  :
                  (cmd_w == CMD_STBY)  ? OP_STBY   : op_state;

  //////////////////////////////////////////////////////////////////////
  // Register file and decoded state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_r <= CTRL_RESET;
      sfreq_r <= SFREQ_RESET;
      ninc_r <= NINC_RESET;
      op_state <= OP_PDOWN;
      cmd_strobe <= '0;
      fuse_mode <= 1'b0;
    end else begin
      if (ctrl_hi_wr) begin
        ctrl_r[15:8] <= wr.data;
      end
      if (wr.en && (wr.addr == ADDR_CTRL_LO)) begin
        ctrl_r[7:0] <= wr.data;
      end
      if (wr.en && (wr.addr == ADDR_SFREQ_HI)) begin
        sfreq_r[23:16] <= wr.data;
      end
      if (wr.en && (wr.addr == ADDR_SFREQ_MD)) begin
        sfreq_r[15:8] <= wr.data;
      end
      if (wr.en && (wr.addr == ADDR_SFREQ_LO)) begin
        sfreq_r[7:0] <= wr.data;
      end
      if (wr.en && (wr.addr == ADDR_NINC_HI)) begin
        ninc_r[NINC_MSB] <= wr.data[0];
      end
      if (wr.en && (wr.addr == ADDR_NINC_LO)) begin
        ninc_r[7:0] <= wr.data;
      end
      op_state <= op_nxt;
      cmd_strobe.init_f <= ctrl_hi_wr && (cmd_w == CMD_INIT);
      cmd_strobe.sweep <= ctrl_hi_wr && (cmd_w == CMD_SWEEP);
      cmd_strobe.incr <= ctrl_hi_wr && (cmd_w == CMD_INCR);
      cmd_strobe.rpt <= ctrl_hi_wr && (cmd_w == CMD_REPEAT);
      cmd_strobe.temp <= ctrl_hi_wr && (cmd_w == CMD_TEMP);
      // Entry wins over a no-op in the same cycle
      fuse_mode <= fuse_enter | (fuse_mode & ~is_nop);
    end
  end

  // Result capture; checksum is the XOR of the four result bytes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      real_r <= RES_RESET;
      imag_r <= RES_RESET;
      chk_r <= CHK_RESET;
    end else if (res_valid) begin
      real_r <= res_real;
      imag_r <= res_imag;
      chk_r <= res_real[15:8] ^ res_real[7:0]
             ^ res_imag[15:8] ^ res_imag[7:0];
    end
  end

  // Outputs: flop slices, except sda_out which is tied low
  assign ctrl_word  = ctrl_r;
  assign start_freq = sfreq_r;
  assign num_incr   = ninc_r;
  assign ext_cal    = ctrl_r[EXTCAL_BIT];
  assign gain_x1    = ctrl_r[GAIN_BIT];
  assign sda_oe     = sda_oe_r;
  assign sda_out    = 1'b0;  // Open drain: only ever pulls low

  //////////////////////////////////////////////////////////////////////
  // Assertions
  ctrl_reset_a: assert property (@(posedge ref_clk)
    reset |=> (ctrl_r == CTRL_RESET) && (op_state == OP_PDOWN))
    else $error("control word not at reset value");
  ctrl_hi_write_a: assert property (@(posedge ref_clk)
    disable iff (reset) ctrl_hi_wr |=> ctrl_r[15:8] == $past(wr.data))
    else $error("high control byte not stored");
  ctrl_lo_write_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    (wr.en && (wr.addr == ADDR_CTRL_LO))
      |=> ctrl_r[7:0] == $past(wr.data) && $stable(ctrl_r[15:8]))
    else $error("low control byte not stored");
  init_strobe_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    (ctrl_hi_wr && cmd_w == CMD_INIT)
      |=> cmd_strobe.init_f && op_state == OP_ACTIVE ##1 !cmd_strobe.init_f)
    else $error("init command not decoded");
  pdown_cmd_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    (ctrl_hi_wr && cmd_w == CMD_PDOWN) |=> op_state == OP_PDOWN)
    else $error("power down not entered");
  reserved_cmd_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    (ctrl_hi_wr && !is_run && cmd_w != CMD_PDOWN && cmd_w != CMD_STBY)
      |=> $stable(op_state) && cmd_strobe == '0)
    else $error("reserved or no-op code acted");
  nop_fuse_a: assert property (@(posedge ref_clk)
    disable iff (reset) (is_nop && !fuse_enter) |=> !fuse_mode)
    else $error("no-op did not leave fuse mode");
  pec_block_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    (data_byte && pec_s && !(pend_r && pec_ok)) |=> $stable(ctrl_r))
    else $error("control updated without good PEC");
  checksum_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    res_valid |=> chk_r == (real_r[15:8] ^ real_r[7:0]
                          ^ imag_r[15:8] ^ imag_r[7:0]))
    else $error("checksum not regenerated");
  ninc_width_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    (sb_r == SB_TX && bit_r == 4'h0 && $past(ptr_r) == ADDR_NINC_HI
     && $changed(sb_r)) |-> tx_r[7:1] == 7'h00)
    else $error("increment count high bits not zero");

  init_cmd_c: cover property (@(posedge ref_clk) cmd_strobe.init_f);
  pec_commit_c: cover property (@(posedge ref_clk) pec_byte && pec_ok);
  pec_reject_c: cover property (@(posedge ref_clk) pec_byte && !pec_ok);
  read_byte_c: cover property (@(posedge ref_clk) sb_r == SB_RACK);

endmodule : icd_top

/* design/icd_pkg.sv */
// Constants and types shared by the impedance control decoder
package icd_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL_HI  = 8'h80;
  localparam logic [7:0] ADDR_CTRL_LO  = 8'h81;
  localparam logic [7:0] ADDR_SFREQ_HI = 8'h82;
  localparam logic [7:0] ADDR_SFREQ_MD = 8'h83;
  localparam logic [7:0] ADDR_SFREQ_LO = 8'h84;
  localparam logic [7:0] ADDR_NINC_HI  = 8'h88;
  localparam logic [7:0] ADDR_NINC_LO  = 8'h89;
  localparam logic [7:0] ADDR_REAL_HI  = 8'h94;
  localparam logic [7:0] ADDR_REAL_LO  = 8'h95;
  localparam logic [7:0] ADDR_IMAG_HI  = 8'h96;
  localparam logic [7:0] ADDR_IMAG_LO  = 8'h97;
  localparam logic [7:0] ADDR_CHKSUM   = 8'h98;

  // Reset values
  localparam logic [15:0] CTRL_RESET  = 16'hA000;
  localparam logic [23:0] SFREQ_RESET = 24'h000000;
  localparam logic [8:0]  NINC_RESET  = 9'h000;
  localparam logic [15:0] RES_RESET   = 16'h0000;
  localparam logic [7:0]  CHK_RESET   = 8'h00;

  // Control word field positions and increment count MSB
  localparam int CMD_MSB    = 15;
  localparam int CMD_LSB    = 11;
  localparam int EXTCAL_BIT = 10;
  localparam int GAIN_BIT   = 7;
  localparam int NINC_MSB   = 8;

  // Command field codes
  localparam logic [4:0] CMD_NOP    = 5'h00;
  localparam logic [4:0] CMD_INIT   = 5'h01;
  localparam logic [4:0] CMD_SWEEP  = 5'h02;
  localparam logic [4:0] CMD_INCR   = 5'h03;
  localparam logic [4:0] CMD_REPEAT = 5'h04;
  localparam logic [4:0] CMD_TEMP   = 5'h09;
  localparam logic [4:0] CMD_PDOWN  = 5'h0A;
  localparam logic [4:0] CMD_STBY   = 5'h0B;

  // Serial bus: slave address (arbitrary value) and PEC polynomial
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Operating state, Gray coded
  typedef enum logic [1:0] {
    OP_PDOWN  = 2'h0,
    OP_STBY   = 2'h1,
    OP_ACTIVE = 2'h3
  } icd_op_t;

  // Serial byte engine state, Gray coded along the usual path
  typedef enum logic [2:0] {
    SB_IDLE = 3'h0,
    SB_RX   = 3'h1,
    SB_ACK  = 3'h3,
    SB_TX   = 3'h2,
    SB_RACK = 3'h6
  } icd_sb_t;

  // One-cycle command strobes
  typedef struct packed {
    logic init_f;
    logic sweep;
    logic incr;
    logic rpt;
    logic temp;
  } icd_cmd_t;

  // Committed register write
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } icd_wr_t;

endpackage : icd_pkg

/* design/icd_sync.sv */
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module icd_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;  // First stage, read only by the second

  // Two stages; idle high so a released bus looks idle after reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_r   <= '1;
      sync_out <= '1;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : icd_sync

/* testbench/icd_host.sv */
// Host bus master model for the two-wire serial pins
`timescale 1ns/1ns
module icd_host (
  input  wire logic ref_clk,  // System clock, host moves on its falls
  input  wire logic sda_w,    // Resolved data wire with pull-up
  output logic      scl,      // Bus clock, idles high
  output logic      sda_low   // High while the host pulls data low
);
  // Phase length in cycles; the device needs at least 8
  localparam int PH = 10;

  // Bus idle at time zero
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // One bus phase
  task automatic ph();
    repeat (PH) @(negedge ref_clk);
  endtask : ph

  // Start or repeated start: data falls while the clock is high
  task automatic bus_start();
    sda_low = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_low = 1'b1;
    ph();
    scl = 1'b0;
    ph();
  endtask : bus_start

  // Stop: data rises while the clock is high
  task automatic bus_stop();
    sda_low = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_low = 1'b0;
    ph();
  endtask : bus_stop

  // One bit; the extra cycle keeps data from moving with the clock fall
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    ph();
    scl = 1'b1;
    repeat (PH / 2) @(negedge ref_clk);
    s = sda_w;
    repeat (PH / 2) @(negedge ref_clk);
    scl = 1'b0;
    @(negedge ref_clk);
  endtask : bit_io

  // Send a byte, return the device acknowledge
  task automatic tx_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : tx_byte

  // Receive a byte; acknowledge only when more bytes are wanted
  task automatic rx_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~more, s);
  endtask : rx_byte
endmodule : icd_host

/* testbench/tb.sv */
// Self-checking bench for the impedance control decoder
`timescale 1ns/1ns
module tb;
  import icd_pkg::*;
  localparam int LIMIT = 60000;  // Cycle ceiling, about 2.7 times the run length of some 22400 cycles
  logic        ref_clk, reset, pec_en, fuse_enter, res_valid;
  logic [15:0] res_real, res_imag, ctrl_word;
  logic        scl, sda_low, sda_w, sda_out, sda_oe, ok;
  logic [23:0] start_freq;
  logic [8:0]  num_incr;
  icd_cmd_t    cmd_strobe;
  icd_op_t     op_state;
  logic        fuse_mode, ext_cal, gain_x1;
  logic [4:0]  seen;      // Strobes caught since last clear
  int          mismatches, tests_run, cycles;

  // Open-drain wire: pull-up unless either party pulls low
  assign sda_w = (sda_oe ? sda_out : 1'b1) & ~sda_low;

  icd_top uut (.ref_clk(ref_clk), .reset(reset), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .pec_en(pec_en),
    .fuse_enter(fuse_enter), .res_valid(res_valid), .res_real(res_real),
    .res_imag(res_imag), .ctrl_word(ctrl_word), .start_freq(start_freq),
    .num_incr(num_incr), .cmd_strobe(cmd_strobe), .op_state(op_state),
    .fuse_mode(fuse_mode), .ext_cal(ext_cal), .gain_x1(gain_x1));

  icd_host host (.ref_clk(ref_clk), .sda_w(sda_w), .scl(scl),
    .sda_low(sda_low));

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Strobes are one cycle wide, so collect them; hang guard too
  always @(posedge ref_clk) begin
    seen <= seen | cmd_strobe;
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // CRC-8 step, polynomial from the package, MSB first
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    c = c ^ b;
    repeat (8) c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    return c;
  endfunction : crc8

  // Write n bytes high first; pm 0 no check byte, 1 good, 2 corrupted
  task automatic wr(input logic [7:0] p, input int n,
                    input logic [23:0] d, input int pm);
    logic [7:0] crc;
    logic       a;
    crc = crc8(crc8(8'h00, {DEV_ADDR, 1'b0}), p);
    ok = 1'b1;
    host.bus_start();
    host.tx_byte({DEV_ADDR, 1'b0}, a);
    ok &= a;
    host.tx_byte(p, a);
    ok &= a;
    for (int i = n - 1; i >= 0; i--) begin
      host.tx_byte(d[i*8 +: 8], a);
      ok &= a;
      crc = crc8(crc, d[i*8 +: 8]);
    end
    if (pm != 0) begin  // One checked byte per transaction
      host.tx_byte((pm == 1) ? crc : ~crc, a);
      ok &= a;
    end
    host.bus_stop();
  endtask : wr

  // Read n bytes (1 or 2) from pointer p, high byte first
  task automatic rd(input logic [7:0] p, input int n,
                    output logic [15:0] v);
    logic [7:0] b;
    logic       a;
    host.bus_start();
    host.tx_byte({DEV_ADDR, 1'b0}, a);
    host.tx_byte(p, a);
    host.bus_start();
    host.tx_byte({DEV_ADDR, 1'b1}, a);
    v = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      host.rx_byte(i != 0, b);
      v[i*8 +: 8] = b;
    end
    host.bus_stop();
  endtask : rd

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    logic [15:0] v;
    chk(ctrl_word, 16'hA000);
    chk(op_state, OP_PDOWN);
    rd(ADDR_CTRL_HI, 2, v);
    chk(v, 16'hA000);
  endtask : t_reset

  // Zero command with calibration bit: options stored, nothing fired
  task automatic t_ctrl();
    logic [15:0] v;
    seen = 5'h00;
    wr(ADDR_CTRL_LO, 1, 24'h000080, 0);
    wr(ADDR_CTRL_HI, 1, 24'h000004, 0);
    rd(ADDR_CTRL_HI, 2, v);
    chk(v, 16'h0480);
    chk(ext_cal, 1'b1);
    chk(gain_x1, 1'b1);
    chk(seen, 5'h00);
    chk(op_state, OP_PDOWN);
    wr(ADDR_CTRL_LO, 1, 24'h000000, 0);
    chk(gain_x1, 1'b0);
  endtask : t_ctrl

  // Every defined code plus reserved 05h; reserved and zero codes keep the state
  task automatic t_cmds();
    logic [4:0] cd [9] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h09, 5'h0B,
                           5'h05, 5'h0A, 5'h00};
    logic [4:0] se [9] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00,
                           5'h00, 5'h00, 5'h00};
    logic [1:0] oe [9] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h1,
                           2'h1, 2'h0, 2'h0};
    for (int i = 0; i < 9; i++) begin
      seen = 5'h00;
      wr(ADDR_CTRL_HI, 1, {16'h0000, cd[i], 3'b000}, 0);
      chk(seen, se[i]);
      chk(op_state, oe[i]);
      chk(ctrl_word[15:11], cd[i]);
    end
    chk(ext_cal, 1'b0);
  endtask : t_cmds

  task automatic t_fuse();
    fuse_enter = 1'b1;
    @(negedge ref_clk);
    fuse_enter = 1'b0;
    @(negedge ref_clk);
    chk(fuse_mode, 1'b1);
    wr(ADDR_CTRL_HI, 1, 24'h000000, 0);
    chk(fuse_mode, 1'b0);
  endtask : t_fuse

  // Multi-byte writes rely on pointer increment
  task automatic t_cfg();
    logic [15:0] v;
    wr(ADDR_SFREQ_HI, 3, 24'h123456, 0);
    chk(start_freq, 24'h123456);
    wr(ADDR_NINC_HI, 2, 24'h00FF34, 0);
    chk(num_incr, 9'h134);
    rd(ADDR_NINC_HI, 1, v);
    chk(v, 16'h0001);
  endtask : t_cfg

  // Two result sets, then a write that must not land
  task automatic t_res();
    logic [15:0] v;
    logic [15:0] rr [2] = '{16'hA1B2, 16'h0102};
    logic [15:0] ri [2] = '{16'hC3D4, 16'h0408};
    for (int k = 0; k < 2; k++) begin
      res_real = rr[k];
      res_imag = ri[k];
      res_valid = 1'b1;
      @(negedge ref_clk);
      res_valid = 1'b0;
      rd(ADDR_REAL_HI, 2, v);
      chk(v, rr[k]);
      rd(ADDR_IMAG_HI, 2, v);
      chk(v, ri[k]);
      rd(ADDR_CHKSUM, 1, v);
      chk(v, rr[k][15:8] ^ rr[k][7:0] ^ ri[k][15:8] ^ ri[k][7:0]);
    end
    wr(ADDR_REAL_HI, 1, 24'h000055, 0);
    rd(ADDR_REAL_HI, 2, v);
    chk(v, 16'h0102);
  endtask : t_res

  // Checked writes: good byte lands, corrupted byte is refused
  task automatic t_pec();
    pec_en = 1'b1;
    repeat (4) @(negedge ref_clk);
    wr(ADDR_CTRL_HI, 1, 24'h000058, 1);
    chk(ok, 1'b1);
    chk(ctrl_word[15:8], 8'h58);
    seen = 5'h00;
    wr(ADDR_CTRL_HI, 1, 24'h000008, 2);
    chk(ok, 1'b0);
    chk(ctrl_word[15:8], 8'h58);
    chk(seen, 5'h00);
    chk(op_state, OP_STBY);
    pec_en = 1'b0;
  endtask : t_pec

  // Mid-run reset brings back the power-up control word and state
  task automatic t_rerst();
    reset = 1'b1;
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(ctrl_word, CTRL_RESET);
    chk(op_state, OP_PDOWN);
    chk(fuse_mode, 1'b0);
  endtask : t_rerst

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic results();
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // Main sequence; inputs move on falling edges
  initial begin
    {reset, pec_en, fuse_enter, res_valid} = 4'b1000;
    {res_real, res_imag} = 32'h0000_0000;
    {mismatches, tests_run, cycles, seen} = '0;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_reset();
    t_ctrl();
    t_cmds();
    t_fuse();
    t_cfg();
    t_res();
    t_pec();
    t_rerst();
    results();
  end
endmodule : tb
